//--- pkg/ext_mem_pkg.sv
// Purpose: shared constants and types of the external memory interface
// Assumes: 125 MHz core clock, 24-bit external address, 32-bit data bus
// Notes:   width codes are shared by physical width and data size fields
`default_nettype none

package ext_mem_pkg;

   // width / size field encodings (code 2'd3 is treated as 32 bits)
   localparam logic [1:0]  WIDTH_8           = 2'd0;
   localparam logic [1:0]  WIDTH_16          = 2'd1;
   localparam logic [1:0]  WIDTH_32          = 2'd2;

   // bus geometry
   localparam int          ADDR_W            = 24;
   localparam int          DATA_W            = 32;
   localparam int          LANES             = 4;

   // address decode: peripheral window first, then set one, rest is set zero
   localparam logic [23:0] PERIPH_BASE       = 24'h800000;
   localparam logic [23:0] PERIPH_LIMIT      = 24'h8fffff;
   localparam logic [23:0] SET1_BASE         = 24'h900000;
   localparam logic [23:0] SET1_LIMIT        = 24'hffffff;

   // strobe timing
   localparam int          CLK_PERIOD_NS     = 8;
   localparam int          MEM_STROBE_NS     = 24;
   localparam int          IO_STROBE_NS      = 48;
   localparam logic [2:0]  MEM_STROBE_CYCLES =
      3'((MEM_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0]  IO_STROBE_CYCLES  =
      3'((IO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // reset / idle values
   localparam logic [3:0]  IDLE_PINS         = 4'hf;
   localparam logic [23:0] ADDR_RESET        = 24'h000000;
   localparam logic [31:0] DATA_RESET        = 32'h00000000;

   typedef enum logic [1:0] {TGT_SET0, TGT_SET1, TGT_PERIPH} target_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE} bus_state_t;

endpackage : ext_mem_pkg

`default_nettype wire

//--- pkg/lane_if.sv
// Purpose: carrier between the access sequencer and one strobe-set pin decoder
// Assumes: pins are active low enables or plain address bits
// Notes:   ctrl side drives the access, lane side returns next pin values
`default_nettype none

interface lane_if;
   import ext_mem_pkg::*;
   logic [1:0] width;
   logic [3:0] mask;
   logic [1:0] q_low;
   logic       active;
   logic [3:0] pins_n;

   modport ctrl (output width, output mask, output q_low, output active, input pins_n);
   modport lane (input width, input mask, input q_low, input active, output pins_n);
endinterface : lane_if

`default_nettype wire

//--- src/ext_mem_if.sv
// Purpose: external memory interface with two strobe sets and a peripheral strobe
// Assumes: set configuration inputs come from registers on the same clock
// Notes:   one bus access in flight; strobes drop for a setup cycle between beats
`default_nettype none

// Overview of operation
// - 24-bit address bus, 32-bit data bus, two strobe sets, one peripheral strobe.
// - one program and two data areas, each configured independently.
// - program width pin high selects 16-bit, low selects 32-bit program memory.
// - 16-bit program memory fetches two halves from consecutive addresses.
// - each strobe set has four pins and owns a fixed address range.
// - each set has physical width and data size, 8, 16 or 32, independent.
// - smaller data size splits a physical word into consecutive addressed units.
// - 8-bit width: lanes 2,3 give low address, lane 0 selects, lane 1 idle.
// - 16-bit width: lane 3 gives low address, lanes 0,1 enable, lane 2 idle.
// - 32-bit width: all four pins are byte enables, one per lane.
// - peripheral strobe is one pin, own range, 32-bit data on 32-bit memory only.
// - peripheral cycles use longer strobe timing than memory sets.
// - 16-bit memory moves 32-bit data and program words as two halves.
// - configuration from pin and set inputs, changes apply without reset.
// - bus clock phases have a period of two core clocks.
module ext_mem_if
   import ext_mem_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              program_width_select,
   input  wire logic [1:0]        set0_phys_width,
   input  wire logic [1:0]        set0_data_size,
   input  wire logic [1:0]        set1_phys_width,
   input  wire logic [1:0]        set1_data_size,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic              req_fetch,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic [ADDR_W-1:0]      ext_addr,
   input  wire logic [DATA_W-1:0] ext_data_in,
   output logic [DATA_W-1:0]      ext_data_out,
   output logic                   ext_data_oe,
   output logic                   ext_read_not_write,
   output logic [LANES-1:0]       memory_strobe_set_zero_n,
   output logic [LANES-1:0]       memory_strobe_set_one_n,
   output logic                   peripheral_strobe_n,
   output logic                   bus_clock_phase_one,
   output logic                   bus_clock_phase_three
);

   typedef struct packed {
      bus_state_t        st;
      logic              h1;
      logic              h3;
      logic              program_width_select_s1;
      logic              program_width_select_s2;
      logic [31:0]       din_s1;
      logic [31:0]       din_s2;
      logic              write;
      target_t           target;
      logic [1:0]        pw;
      logic [1:0]        ds;
      logic [23:0]       addr;
      logic [31:0]       wdata;
      logic [1:0]        beat;
      logic [2:0]        cnt;
      logic [31:0]       acc;
      logic              ready;
      logic              rsp_valid;
      logic [31:0]       rdata;
      logic [23:0]       ext_addr;
      logic [31:0]       dout;
      logic              doe;
      logic              rnw;
      logic [3:0]        pins0;
      logic [3:0]        pins1;
      logic              io_n;
   } state_t;

   state_t r_reg;
   state_t r_next;

   lane_if lanes0 ();
   lane_if lanes1 ();

   logic [1:0]  d_shift;
   logic [25:0] d_q;
   logic [1:0]  d_unit;
   logic [1:0]  d_off;
   logic [2:0]  d_nbytes;
   logic [2:0]  d_beats;
   logic [7:0]  d_mask8;
   logic [3:0]  d_mask;
   logic [4:0]  d_lane_shift;
   logic [23:0] d_ext_addr;
   logic [31:0] d_wdata;
   logic [31:0] d_rd;
   logic        d_last;
   target_t     a_target;
   logic [1:0]  a_pw;
   logic [1:0]  a_ds;

   // bit mask covering a width code
   function automatic logic [31:0] width_mask(input logic [1:0] code);
      logic [31:0] m;
      m = 32'hffffffff;
      if (code == WIDTH_8)
         m = 32'h000000ff;
      else if (code == WIDTH_16)
         m = 32'h0000ffff;
      return m;
   endfunction

   // clamp the spare code onto 32 bits so shifts stay in range
   function automatic logic [1:0] clamp_width(input logic [1:0] code);
      return (code == 2'd3) ? WIDTH_32 : code;
   endfunction

   // address decode and per-area configuration of a new request
   always_comb
   begin
      if (req_addr >= PERIPH_BASE && req_addr <= PERIPH_LIMIT)
         a_target = TGT_PERIPH;
      else if (req_addr >= SET1_BASE && req_addr <= SET1_LIMIT)
         a_target = TGT_SET1;
      else
         a_target = TGT_SET0;
      unique case (a_target)
         TGT_SET1:
         begin
            a_pw = clamp_width(set1_phys_width);
            a_ds = clamp_width(set1_data_size);
         end
         TGT_PERIPH:
         begin
            a_pw = WIDTH_32;
            a_ds = WIDTH_32;
         end
         default:
         begin
            a_pw = clamp_width(set0_phys_width);
            a_ds = clamp_width(set0_data_size);
         end
      endcase
      // program fetch width follows the pin outside the peripheral window, word is always 32 bits
      if (req_fetch && a_target != TGT_PERIPH)
      begin
         a_pw = r_reg.program_width_select_s2 ? WIDTH_16 : WIDTH_32;
         a_ds = WIDTH_32;
      end
   end

   // beat descriptor: physical unit address, lane offset and byte mask
   always_comb
   begin
      if (r_reg.ds < r_reg.pw)
      begin
         d_shift  = r_reg.pw - r_reg.ds;
         d_q      = {2'b00, r_reg.addr} >> d_shift;
         d_unit   = r_reg.addr[1:0] & ((2'b01 << d_shift) - 2'b01);
         d_off    = d_unit << r_reg.ds;
         d_nbytes = 3'b001 << r_reg.ds;
         d_beats  = 3'b001;
      end
      else
      begin
         d_shift  = r_reg.ds - r_reg.pw;
         d_q      = ({2'b00, r_reg.addr} << d_shift) + 26'(r_reg.beat);
         d_unit   = 2'b00;
         d_off    = 2'b00;
         d_nbytes = 3'b001 << r_reg.pw;
         d_beats  = 3'b001 << d_shift;
      end
      d_mask8      = ((8'h01 << d_nbytes) - 8'h01) << d_off;
      d_mask       = d_mask8[3:0];
      d_lane_shift = 5'({r_reg.beat, 3'b000} << r_reg.pw);
      d_ext_addr   = 24'(d_q >> (2'd2 - r_reg.pw));
      d_last       = (3'(r_reg.beat) == d_beats - 3'b001);
      // low half goes first, higher halves follow at higher addresses
      if (r_reg.ds < r_reg.pw)
         d_wdata = r_reg.wdata << {d_off, 3'b000};
      else
         d_wdata = r_reg.wdata >> d_lane_shift;
      if (r_reg.ds < r_reg.pw)
         d_rd = (r_reg.din_s2 >> {d_off, 3'b000}) & width_mask(r_reg.ds);
      else
         d_rd = r_reg.acc | ((r_reg.din_s2 & width_mask(r_reg.pw)) << d_lane_shift);
   end

   // feed both pin decoders; only the addressed one is active
   assign lanes0.width  = r_reg.pw;
   assign lanes0.mask   = d_mask;
   assign lanes0.q_low  = d_q[1:0];
   assign lanes0.active = (r_reg.target == TGT_SET0);
   assign lanes1.width  = r_reg.pw;
   assign lanes1.mask   = d_mask;
   assign lanes1.q_low  = d_q[1:0];
   assign lanes1.active = (r_reg.target == TGT_SET1);

   lane_decode u_lane0
   (
      .pins (lanes0)
   );

   lane_decode u_lane1
   (
      .pins (lanes1)
   );

   // sequencer: idle, setup of one beat, strobe hold, then next beat or answer
   always_comb
   begin
      r_next           = r_reg;
      r_next.h1        = ~r_reg.h1;
      r_next.h3        = r_reg.h1;
      r_next.program_width_select_s1   = program_width_select;
      r_next.program_width_select_s2   = r_reg.program_width_select_s1;
      r_next.din_s1    = ext_data_in;
      r_next.din_s2    = r_reg.din_s1;
      r_next.rsp_valid = 1'b0;
      unique case (r_reg.st)
         ST_IDLE:
         begin
            r_next.ready = 1'b1;
            if (r_reg.ready && req_valid)
            begin
               r_next.st     = ST_SETUP;
               r_next.ready  = 1'b0;
               r_next.write  = req_write && !req_fetch;
               r_next.target = a_target;
               r_next.pw     = a_pw;
               r_next.ds     = a_ds;
               r_next.addr   = req_addr;
               r_next.wdata  = req_wdata;
               r_next.beat   = 2'b00;
               r_next.acc    = DATA_RESET;
            end
         end
         ST_SETUP:
         begin
            // address, data and pins settle together at strobe start
            r_next.st       = ST_STROBE;
            r_next.ext_addr = d_ext_addr;
            r_next.dout     = d_wdata;
            r_next.doe      = r_reg.write;
            r_next.rnw      = !r_reg.write;
            r_next.pins0    = lanes0.pins_n;
            r_next.pins1    = lanes1.pins_n;
            r_next.io_n     = (r_reg.target != TGT_PERIPH);
            if (r_reg.target == TGT_PERIPH)
               r_next.cnt = IO_STROBE_CYCLES - 3'd1;
            else
               r_next.cnt = MEM_STROBE_CYCLES - 3'd1;
         end
         ST_STROBE:
         begin
            if (r_reg.cnt != 3'd0)
               r_next.cnt = r_reg.cnt - 3'd1;
            else
            begin
               // end of beat: release the bus so no strobe stays low between beats
               r_next.pins0 = IDLE_PINS;
               r_next.pins1 = IDLE_PINS;
               r_next.io_n  = 1'b1;
               r_next.doe   = 1'b0;
               r_next.rnw   = 1'b1;
               r_next.acc   = d_rd;
               if (d_last)
               begin
                  r_next.st        = ST_IDLE;
                  r_next.rsp_valid = 1'b1;
                  r_next.rdata     = r_reg.write ? DATA_RESET : d_rd;
               end
               else
               begin
                  r_next.st   = ST_SETUP;
                  r_next.beat = r_reg.beat + 2'b01;
               end
            end
         end
      endcase
   end

   // single register stage; clock enable freezes everything
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         r_reg          <= '0;
         r_reg.st       <= ST_IDLE;
         r_reg.target   <= TGT_SET0;
         r_reg.h3       <= 1'b1;
         r_reg.ext_addr <= ADDR_RESET;
         r_reg.rnw      <= 1'b1;
         r_reg.pins0    <= IDLE_PINS;
         r_reg.pins1    <= IDLE_PINS;
         r_reg.io_n     <= 1'b1;
      end
      else if (ce)
         r_reg <= r_next;
   end

   // every output comes straight from the state register
   assign req_ready                = r_reg.ready;
   assign rsp_valid                = r_reg.rsp_valid;
   assign rsp_rdata                = r_reg.rdata;
   assign ext_addr                 = r_reg.ext_addr;
   assign ext_data_out             = r_reg.dout;
   assign ext_data_oe              = r_reg.doe;
   assign ext_read_not_write       = r_reg.rnw;
   assign memory_strobe_set_zero_n = r_reg.pins0;
   assign memory_strobe_set_one_n  = r_reg.pins1;
   assign peripheral_strobe_n      = r_reg.io_n;
   assign bus_clock_phase_one      = r_reg.h1;
   assign bus_clock_phase_three    = r_reg.h3;

endmodule // ext_mem_if

`default_nettype wire

//--- src/lane_decode.sv
// Purpose: maps physical width, byte mask and low address onto four set pins
// Assumes: enables are active low, address pins carry true level
// Notes:   purely combinational; the caller registers the result
`default_nettype none

module lane_decode
   import ext_mem_pkg::*;
(
   lane_if.lane pins
);

   // pin roles follow the physical width of the set
   always_comb
   begin
      pins.pins_n = IDLE_PINS;
      if (pins.active)
      begin
         unique case (pins.width)
            WIDTH_8:
            begin
               pins.pins_n[0] = ~pins.mask[0];
               pins.pins_n[1] = 1'b1;
               pins.pins_n[2] = pins.q_low[1];
               pins.pins_n[3] = pins.q_low[0];
            end
            WIDTH_16:
            begin
               pins.pins_n[1:0] = ~pins.mask[1:0];
               pins.pins_n[2]   = 1'b1;
               pins.pins_n[3]   = pins.q_low[0];
            end
            default:
               pins.pins_n = ~pins.mask;
         endcase
      end
   end

endmodule // lane_decode

`default_nettype wire

//--- tb/ext_mem_if_monitor.sv
// Purpose: concurrent checks on the external memory pins
// Assumes: one clock, synchronous active-low reset
// Notes:   a group is active while any of its pins leaves idle
`default_nettype none

module ext_mem_if_monitor
   import ext_mem_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              req_valid,
   input  wire logic              req_ready,
   input  wire logic              rsp_valid,
   input  wire logic [ADDR_W-1:0] ext_addr,
   input  wire logic              ext_data_oe,
   input  wire logic              ext_read_not_write,
   input  wire logic [LANES-1:0]  memory_strobe_set_zero_n,
   input  wire logic [LANES-1:0]  memory_strobe_set_one_n,
   input  wire logic              peripheral_strobe_n,
   input  wire logic              bus_clock_phase_one,
   input  wire logic              bus_clock_phase_three
);
   timeunit 1ns;
   timeprecision 1ns;
   logic s0_act;
   logic s1_act;
   logic io_act;
   logic any_act;

   // address pins count as activity too, they idle high
   assign s0_act  = memory_strobe_set_zero_n != IDLE_PINS;
   assign s1_act  = memory_strobe_set_one_n != IDLE_PINS;
   assign io_act  = !peripheral_strobe_n;
   assign any_act = s0_act || s1_act || io_act;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // a memory beat holds pins and address two more cycles, then idles
   sequence mem_beat(pins, act);
      ($stable(pins) && $stable(ext_addr))[*2] ##1 !act;
   endsequence

   sequence io_beat;
      (io_act && $stable(ext_addr))[*5] ##1 !io_act;
   endsequence

   // hold is judged from the cycle after the strobe rises, against its first cycle
   a_set0_beat_len: assert property ($rose(s0_act) |=> mem_beat(memory_strobe_set_zero_n, s0_act))
      else $error("set zero beat length or hold wrong");
   a_set1_beat_len: assert property ($rose(s1_act) |=> mem_beat(memory_strobe_set_one_n, s1_act))
      else $error("set one beat length or hold wrong");
   a_io_beat_len: assert property ($rose(io_act) |=> io_beat)
      else $error("peripheral strobe length wrong");
   a_one_group: assert property ($onehot0({s0_act, s1_act, io_act}))
      else $error("more than one strobe group active");
   a_idle_when_ready: assert property (req_ready |-> !any_act)
      else $error("strobe active while idle");
   a_rsp_after_strobe: assert property (rsp_valid |-> !any_act && $past(any_act))
      else $error("response not right after last strobe");
   a_write_drives_bus: assert property (!ext_read_not_write |-> ext_data_oe && any_act)
      else $error("write strobe without driven data");
   a_phase_toggle: assert property (ce && resetn |=> bus_clock_phase_one != $past(bus_clock_phase_one))
      else $error("bus clock phase did not toggle");
   a_phase_pair: assert property (bus_clock_phase_three != bus_clock_phase_one)
      else $error("bus clock phases not opposite");
   a_take_answer: assert property (req_valid && req_ready && ce |=> !req_ready ##[3:19] rsp_valid)
      else $error("request not answered in time");

endmodule // ext_mem_if_monitor

bind ext_mem_if ext_mem_if_monitor ext_mem_if_monitor_inst (
   .clk, .resetn, .ce, .req_valid, .req_ready, .rsp_valid, .ext_addr, .ext_data_oe, .ext_read_not_write,
   .memory_strobe_set_zero_n, .memory_strobe_set_one_n, .peripheral_strobe_n, .bus_clock_phase_one,
   .bus_clock_phase_three
);

`default_nettype wire

//--- tb/ext_mem_model.sv
// Purpose: external memory and peripheral bank seen by the data pins
// Assumes: zero wait states, data valid from the first strobe cycle
// Notes:   released bus shows the inverse of the last value
`default_nettype none

module ext_mem_model
   import ext_mem_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [LANES-1:0]  set0_n,
   input  wire logic [LANES-1:0]  set1_n,
   input  wire logic              io_n,
   input  wire logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0]      data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]  pins;
   logic [31:0] last_reg = 32'h00000000;

   // pattern ties data to address and pins so a wrong lane shows
   assign pins = (set0_n != IDLE_PINS) ? set0_n : (set1_n != IDLE_PINS) ? set1_n : {4{io_n}};
   assign data = (pins != 4'hf) ? {addr[11:0], pins, addr[11:0] ^ 12'h5a5, pins} : ~last_reg;

   // keeps an unselected bus changing, so stale data cannot pass
   always @(posedge clk)
      last_reg <= data;
endmodule // ext_mem_model

`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the external memory interface
// Assumes: partner answers every strobe at once
// Notes:   each access is followed beat by beat and rebuilt
`default_nettype none

module tb_top
   import ext_mem_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk, resetn, ce, program_width_select;
   logic [1:0]        set0_phys_width, set0_data_size, set1_phys_width, set1_data_size;
   logic              req_valid, req_write, req_fetch, req_ready, rsp_valid;
   logic [ADDR_W-1:0] req_addr, ext_addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, ext_data_in, ext_data_out;
   logic              ext_data_oe, ext_read_not_write, peripheral_strobe_n;
   logic              bus_clock_phase_one, bus_clock_phase_three;
   logic [LANES-1:0]  memory_strobe_set_zero_n, memory_strobe_set_one_n;
   int                n_errors, checked;

   ext_mem_if ext_mem_if_inst (.clk, .resetn, .ce, .program_width_select, .set0_phys_width, .set0_data_size,
      .set1_phys_width, .set1_data_size, .req_valid, .req_write, .req_fetch, .req_addr, .req_wdata, .req_ready,
      .rsp_valid, .rsp_rdata, .ext_addr, .ext_data_in, .ext_data_out, .ext_data_oe, .ext_read_not_write,
      .memory_strobe_set_zero_n, .memory_strobe_set_one_n, .peripheral_strobe_n, .bus_clock_phase_one,
      .bus_clock_phase_three);
   ext_mem_model ext_mem_model_inst (.clk, .set0_n(memory_strobe_set_zero_n), .set1_n(memory_strobe_set_one_n),
      .io_n(peripheral_strobe_n), .addr(ext_addr), .data(ext_data_in));

   // 125 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [31:0] pat(input logic [23:0] a, input logic [3:0] p);
      return {a[11:0], p, a[11:0] ^ 12'h5a5, p};
   endfunction

   // set configuration changes between accesses, no reset in between
   task automatic cfg(input logic [1:0] p0, input logic [1:0] d0, input logic [1:0] p1, input logic [1:0] d1);
      @(posedge clk);
      set0_phys_width <= p0;
      set0_data_size  <= d0;
      set1_phys_width <= p1;
      set1_data_size  <= d1;
   endtask

   // one access: issue, follow every beat, then judge pins and data
   task automatic run(input logic wr, input logic fe, input logic [23:0] a, input logic [31:0] wd);
      int          pw, ds, nt, beats, lat, nb, n, unit, off;
      logic [3:0]  ep, msk, bp[4];
      logic [23:0] ea, ba[4];
      logic [31:0] lb, rd, bd[4];
      logic        bw[4], act, prev;
      n = 0;
      while (req_ready !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_fetch <= fe;
      req_addr  <= a;
      req_wdata <= wd;
      // config is read here, a cycle after cfg, once its updates have landed
      nt = (a >= PERIPH_BASE && a <= PERIPH_LIMIT) ? 2 : (a >= SET1_BASE) ? 1 : 0;
      pw = nt == 2 ? 2 : nt == 1 ? int'(set1_phys_width) : int'(set0_phys_width);
      ds = nt == 2 ? 2 : nt == 1 ? int'(set1_data_size) : int'(set0_data_size);
      pw = (fe && nt != 2) ? (program_width_select ? 1 : 2) : pw;
      ds = fe ? 2 : ds;
      beats = ds > pw ? 1 << (ds - pw) : 1;
      @(posedge clk);
      req_valid <= 1'b0;
      nb = 0;
      lat = 0;
      prev = 1'b0;
      for (int c = 1; c <= 40 && lat == 0; c++)
      begin
         @(posedge clk);
         #1;
         act = memory_strobe_set_zero_n != IDLE_PINS || memory_strobe_set_one_n != IDLE_PINS || !peripheral_strobe_n;
         if (act && !prev && nb < 4)
         begin
            ba[nb] = ext_addr;
            bp[nb] = nt == 2 ? {4{peripheral_strobe_n}} : nt == 1 ? memory_strobe_set_one_n : memory_strobe_set_zero_n;
            bd[nb] = ext_data_out;
            bw[nb] = ext_read_not_write;
            nb++;
         end
         prev = act;
         if (rsp_valid === 1'b1)
            lat = c;
      end
      check(32'(nb), 32'(beats));
      // lat counts from the edge after the take edge: setup plus strobe cycles per beat
      check(32'(lat), 32'(beats * ((nt == 2 ? int'(IO_STROBE_CYCLES) : int'(MEM_STROBE_CYCLES)) + 1)));
      rd = 32'h00000000;
      for (int k = 0; k < beats && k < nb; k++)
      begin
         unit = ds > pw ? int'(a) * beats + k : int'(a) >> (pw - ds);
         off = ds > pw ? 0 : (int'(a) & ((1 << (pw - ds)) - 1)) * (1 << ds);
         msk = 4'(ds > pw ? (1 << (1 << pw)) - 1 : ((1 << (1 << ds)) - 1) << off);
         lb = {{8{msk[3]}}, {8{msk[2]}}, {8{msk[1]}}, {8{msk[0]}}};
         ea = 24'(pw == 0 ? unit >> 2 : pw == 1 ? unit >> 1 : unit);
         ep = pw == 0 ? {unit[0], unit[1], 2'b10} : pw == 1 ? {unit[0], 1'b1, ~msk[1:0]} : ~msk;
         check(32'(ba[k]), 32'(ea));
         if (pw == 0)
            check(32'(bp[k]), 32'(ep));
         else if (pw == 1)
            check(32'(bp[k]), 32'(ep));
         else
            check(32'(bp[k]), 32'(ep));
         check(32'(bw[k]), 32'(!wr || fe));
         if (wr && !fe)
            check(bd[k] & lb, ((wd >> (k * 8 << pw)) << (off * 8)) & lb);
         rd |= ((pat(ea, ep) & lb) >> (off * 8)) << (k * 8 << pw);
      end
      if (!wr || fe)
         check(rsp_rdata, rd);
   endtask

   // whole words on 32-bit set zero
   task automatic t_word;
      cfg(2'h2, 2'h2, 2'h2, 2'h2);
      run(1'b0, 1'b0, 24'h000123, 32'h00000000);
      run(1'b1, 1'b0, 24'h000124, 32'hcafe1234);
   endtask

   // bytes packed four to a 32-bit word on set one, every lane
   task automatic t_bytes32;
      cfg(2'h2, 2'h2, 2'h2, 2'h0);
      for (int i = 0; i < 4; i++)
         run(1'b0, 1'b0, 24'h900004 + 24'(i), 32'h00000000);
      run(1'b1, 1'b0, 24'h900007, 32'h000000a5);
   endtask

   // 16-bit memory: halves, odd bytes, and words split in two; then halves packed on 32-bit set one
   task automatic t_half16;
      cfg(2'h1, 2'h1, 2'h1, 2'h0);
      run(1'b0, 1'b0, 24'h000011, 32'h00000000);
      run(1'b1, 1'b0, 24'h900021, 32'h0000005c);
      cfg(2'h1, 2'h2, 2'h2, 2'h1);
      run(1'b1, 1'b0, 24'h000030, 32'h89abcdef);
      run(1'b0, 1'b0, 24'h000031, 32'h00000000);
      run(1'b0, 1'b0, 24'h900013, 32'h00000000);
   endtask

   // 8-bit memory: four and two beat transfers, and single bytes
   task automatic t_on8;
      cfg(2'h0, 2'h2, 2'h0, 2'h1);
      run(1'b0, 1'b0, 24'h000052, 32'h00000000);
      run(1'b1, 1'b0, 24'h900033, 32'h0000beef);
      run(1'b1, 1'b0, 24'h000053, 32'h13579bdf);
      cfg(2'h0, 2'h0, 2'h0, 2'h1);
      run(1'b0, 1'b0, 24'h000067, 32'h00000000);
      run(1'b0, 1'b0, 24'h900035, 32'h00000000);
   endtask

   // program fetch, width from the pin; code kept off 8-bit memory
   task automatic t_fetch;
      cfg(2'h1, 2'h1, 2'h2, 2'h2);
      @(posedge clk);
      program_width_select <= 1'b1;
      repeat (3) @(posedge clk);
      run(1'b0, 1'b1, 24'h000041, 32'h00000000);
      run(1'b0, 1'b1, 24'h900042, 32'h00000000);
      @(posedge clk);
      program_width_select <= 1'b0;
      repeat (3) @(posedge clk);
      run(1'b0, 1'b1, 24'h000043, 32'h00000000);
   endtask

   // peripheral strobe: slow cycles, whole words, range ends
   task automatic t_periph;
      run(1'b1, 1'b0, 24'h800010, 32'h0f1e2d3c);
      run(1'b0, 1'b0, 24'h8fffff, 32'h00000000);
      run(1'b0, 1'b0, 24'h800000, 32'h00000000);
   endtask

   // clock enable low freezes the bus clock phases, high lets them run again
   task automatic t_freeze;
      logic ph;
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      #1;
      ph = bus_clock_phase_one;
      repeat (3) @(posedge clk);
      #1;
      check(32'(bus_clock_phase_one), 32'(ph));
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      #1;
      check(32'(bus_clock_phase_one), 32'(!ph));
      check(32'(bus_clock_phase_three), 32'(ph));
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      n_errors = 0;
      checked = 0;
      resetn = 1'b0;
      ce = 1'b1;
      program_width_select = 1'b0;
      {set0_phys_width, set0_data_size, set1_phys_width, set1_data_size} = 8'haa;
      {req_valid, req_write, req_fetch} = 3'h0;
      req_addr = 24'h000000;
      req_wdata = 32'h00000000;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_word;
      t_bytes32;
      t_half16;
      t_on8;
      t_fetch;
      t_periph;
      t_freeze;
      close_out;
   end

   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #100000;
      n_errors++;
      close_out;
   end
endmodule // tb_top

`default_nettype wire
